/* pkg/nsis_pkg.sv */
// ----------------------------------------------------------------------
// Shared constants for the status and interrupt summary block.
// ----------------------------------------------------------------------
package nsis_pkg;

  // Register bus geometry and offsets.
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam logic [7:0] STATUS_OFF = 8'h28;
  localparam logic [7:0] MASK_OFF = 8'h38;

  // Width of the flag vector, bits 27 down to 0.
  localparam int unsigned FLAG_W = 28;
  localparam int unsigned FIELD_W = 3;

  // Flag bit positions.
  localparam int unsigned TX_DONE_BIT = 0;
  localparam int unsigned RX_DONE_BIT = 6;
  localparam int unsigned EARLY_TX_BIT = 10;
  localparam int unsigned FATAL_BIT = 13;
  localparam int unsigned EARLY_RX_BIT = 14;

  // Field positions inside the status word.
  localparam int unsigned ABN_SUM_BIT = 15;
  localparam int unsigned NRM_SUM_BIT = 16;
  localparam int unsigned RX_STATE_LSB = 17;
  localparam int unsigned TX_STATE_LSB = 20;
  localparam int unsigned ERR_TYPE_LSB = 23;

  // Contributors: normal = 0,2,6,11,14; abnormal = 1,3,4,5,7..10,12,13,26,27.
  localparam logic [27:0] NORMAL_SRC = 28'h0004845;
  localparam logic [27:0] ABNORMAL_SRC = 28'hC0037BA;
  localparam logic [27:0] FLAG_IMPL = 28'hC007FFF;

  // Values after reset.
  localparam logic [27:0] FLAG_RST = 28'h0000000;
  localparam logic [27:0] MASK_RST = 28'h0000000;
  localparam logic [2:0] FIELD_RST = 3'h0;
  localparam logic [31:0] RDATA_RST = 32'h00000000;

endpackage : nsis_pkg

/* src/nsis_flag_bank.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Bank of sticky flags: hardware set beats every clear.
// ----------------------------------------------------------------------
module nsis_flag_bank #(
  parameter int unsigned WIDTH = 28,
  parameter logic [WIDTH-1:0] RST = {WIDTH{1'b0}}
) (
  input wire logic clk, // Block clock.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic [WIDTH-1:0] set_v, // Hardware set pulses.
  input wire logic [WIDTH-1:0] clr_v, // Software write-one clears.
  input wire logic [WIDTH-1:0] auto_v, // Hardware automatic clears.
  output logic [WIDTH-1:0] flag_q // Flag values.
);

  // One flop per flag; a set in the clearing cycle is never lost.
  for (genvar i = 0; i < WIDTH; i++)
  begin : g_flag
    wire logic flag_d;
    assign flag_d = set_v[i] | (flag_q[i] & ~clr_v[i] & ~auto_v[i]);
    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
        flag_q[i] <= RST[i];
      else
        flag_q[i] <= flag_d;
    end
  end

endmodule : nsis_flag_bank

/* src/nsis_summary.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Normal and abnormal summaries with the early transmit hold.
// ----------------------------------------------------------------------
module nsis_summary (
  input wire logic clk, // Block clock.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire logic [27:0] flag_q, // Current flags.
  input wire logic [27:0] mask_q, // Enables, one means unmasked.
  input wire logic etx_auto, // Early transmit flag auto clear pulse.
  input wire logic etx_sw_clr, // Software wrote one to early transmit.
  output logic normal_q, // Normal summary.
  output logic abnormal_q, // Abnormal summary.
  output logic hold_q // Abnormal kept alive by auto clear.
);

  // ----------------------------------------------------------------------
  // Summary terms.
  // ----------------------------------------------------------------------
  // Only unmasked contributors count.
  wire logic nrm_any;
  wire logic abn_any;
  wire logic hold_set;
  assign nrm_any = |(flag_q & mask_q & nsis_pkg::NORMAL_SRC);
  assign abn_any = |(flag_q & mask_q & nsis_pkg::ABNORMAL_SRC);
  // The hold keeps the line up when the completion that cleared the early
  // flag is itself masked and would otherwise raise nothing.
  assign hold_set = etx_auto & flag_q[nsis_pkg::EARLY_TX_BIT]
    & mask_q[nsis_pkg::EARLY_TX_BIT]
    & ~mask_q[nsis_pkg::TX_DONE_BIT];

  // Summaries are recomputed every cycle from flags, masks and the hold.
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      normal_q <= 1'b0;
      abnormal_q <= 1'b0;
      hold_q <= 1'b0;
    end
    else
    begin
      normal_q <= nrm_any;
      abnormal_q <= abn_any | hold_q;
      hold_q <= hold_set | (hold_q & ~etx_sw_clr);
    end
  end

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence s_etx_hold;
    hold_set ##1 !etx_sw_clr;
  endsequence

  a_normal_follow: assert property (
    nrm_any |=> normal_q)
    else $error("normal summary missed an unmasked flag");
  a_normal_masked: assert property (
    !nrm_any |=> !normal_q)
    else $error("normal summary set with no unmasked flag");
  a_abn_hold: assert property (
    s_etx_hold |=> abnormal_q && hold_q)
    else $error("abnormal summary dropped after auto clear");
  a_abn_drop: assert property (
    !abn_any && !hold_q |=> !abnormal_q)
    else $error("abnormal summary stuck with no source");
  a_abn_follow: assert property (
    abn_any |=> abnormal_q)
    else $error("abnormal summary missed an unmasked flag");

endmodule : nsis_summary

/* src/nsis_top.sv */
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
// Overview of operation
// - Read-only bus error type in bits 25:23, valid while fatal flag set.
// - Read-only transmit process state in bits 22:20, no interrupt.
// - Read-only receive process state in bits 19:17, no interrupt.
// - Normal summary bit 16 ORs flags 0, 2, 6, 11 and 14.
// - Only unmasked flags feed the normal summary.
// - Abnormal summary bit 15 ORs flags 1,3-5,7-10,12,13,26,27.
// - Only unmasked flags feed the abnormal summary.
// - Transmit done setting clears the early transmit flag.
// - That auto clear with transmit done masked keeps abnormal summary set.
// - Early receive flag sets when the first packet buffer fills.
// - Receive done setting clears the early receive flag.
// - Host bus error sets fatal flag and records error type.
// - While fatal flag is set no host bus access starts.
// - Writing one clears a flag; writing zero leaves it.
// - Reading the status register changes nothing.
module nsis_top (
  input wire logic CLK, // Block clock, 100 MHz.
  input wire logic RESETN, // Asynchronous reset, active low.
  input wire logic [7:0] ADDR, // Register byte address.
  input wire logic [31:0] WDATA, // Write data.
  input wire logic WR, // Write strobe, one cycle.
  input wire logic RD, // Read strobe, one cycle.
  output logic [31:0] RDATA, // Read data, cycle after RD.
  input wire logic [27:0] EVENT_SET, // Flag set pulses from the engines.
  input wire logic [2:0] BUS_ERR_TYPE, // Error cause beside bit 13 pulse.
  input wire logic [2:0] TX_STATE, // Transmit process state.
  input wire logic [2:0] RX_STATE, // Receive process state.
  output logic BUS_ACCESS_EN, // High while host bus access is allowed.
  output logic IRQ, // Level interrupt, active high.
  output logic NORMAL_SUMMARY, // Normal summary bit.
  output logic ABNORMAL_SUMMARY // Abnormal summary bit.
);

  // ----------------------------------------------------------------------
  // Address decode.
  // ----------------------------------------------------------------------
  wire logic sel_status;
  wire logic sel_mask;
  wire logic wr_status;
  wire logic wr_mask;
  assign sel_status = (ADDR == nsis_pkg::STATUS_OFF);
  assign sel_mask = (ADDR == nsis_pkg::MASK_OFF);
  assign wr_status = WR & sel_status;
  assign wr_mask = WR & sel_mask;

  // ----------------------------------------------------------------------
  // Flag set and clear terms.
  // ----------------------------------------------------------------------
  logic [27:0] flag_q;
  logic [27:0] mask_q;
  logic [2:0] err_type_q;
  logic [2:0] tx_state_q;
  logic [2:0] rx_state_q;
  logic normal_q;
  logic abnormal_q;
  logic hold_q;
  wire logic [27:0] set_v;
  wire logic [27:0] clr_v;
  wire logic [27:0] auto_v;
  wire logic etx_auto;
  wire logic erx_auto;
  wire logic etx_sw_clr;

  // Only implemented positions can ever be set; reads never touch flags.
  assign set_v = EVENT_SET & nsis_pkg::FLAG_IMPL;
  // Write one clears; zeros and read-only field bits are ignored.
  assign clr_v = wr_status ? (WDATA[27:0] & nsis_pkg::FLAG_IMPL)
    : 28'h0000000;
  // Completion events sweep away their early flags.
  assign etx_auto = set_v[nsis_pkg::TX_DONE_BIT];
  assign erx_auto = set_v[nsis_pkg::RX_DONE_BIT];
  assign auto_v = (28'h0000001 << nsis_pkg::EARLY_TX_BIT) & {28{etx_auto}}
    | (28'h0000001 << nsis_pkg::EARLY_RX_BIT) & {28{erx_auto}};
  assign etx_sw_clr = clr_v[nsis_pkg::EARLY_TX_BIT];

  // ----------------------------------------------------------------------
  // Sticky flags.
  // ----------------------------------------------------------------------
  nsis_flag_bank #(
    .WIDTH(nsis_pkg::FLAG_W),
    .RST(nsis_pkg::FLAG_RST)
  ) u_flags (
    .clk(CLK),
    .resetn(RESETN),
    .set_v(set_v),
    .clr_v(clr_v),
    .auto_v(auto_v),
    .flag_q(flag_q)
  );

  // ----------------------------------------------------------------------
  // Summaries.
  // ----------------------------------------------------------------------
  nsis_summary u_summary (
    .clk(CLK),
    .resetn(RESETN),
    .flag_q(flag_q),
    .mask_q(mask_q),
    .etx_auto(etx_auto),
    .etx_sw_clr(etx_sw_clr),
    .normal_q(normal_q),
    .abnormal_q(abnormal_q),
    .hold_q(hold_q)
  );

  // ----------------------------------------------------------------------
  // Mask register and read-only fields.
  // ----------------------------------------------------------------------
  wire logic fatal_next;
  wire logic [27:0] mask_d;
  assign fatal_next = set_v[nsis_pkg::FATAL_BIT]
    | (flag_q[nsis_pkg::FATAL_BIT] & ~clr_v[nsis_pkg::FATAL_BIT]);
  assign mask_d = wr_mask ? (WDATA[27:0] & nsis_pkg::FLAG_IMPL) : mask_q;

  // Mask is plain read/write storage.
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      mask_q <= nsis_pkg::MASK_RST;
    else
      mask_q <= mask_d;
  end

  // The error cause is latched with the fatal event; it means nothing
  // once software has cleared the fatal flag.
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      err_type_q <= nsis_pkg::FIELD_RST;
    else if (set_v[nsis_pkg::FATAL_BIT])
      err_type_q <= BUS_ERR_TYPE;
  end

  // Process states are mirrored each cycle; they feed no summary.
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      tx_state_q <= nsis_pkg::FIELD_RST;
      rx_state_q <= nsis_pkg::FIELD_RST;
    end
    else
    begin
      tx_state_q <= TX_STATE;
      rx_state_q <= RX_STATE;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs.
  // ----------------------------------------------------------------------
  wire logic [31:0] status_word;
  wire logic [31:0] rdata_d;
  assign status_word = {4'h0, flag_q[27:26], err_type_q, tx_state_q,
    rx_state_q, normal_q, abnormal_q, flag_q[14:0]};
  // Unmapped reads return zero; data stand only in the cycle after RD.
  assign rdata_d = !RD ? 32'h00000000
    : sel_status ? status_word
    : sel_mask ? {4'h0, mask_q}
    : 32'h00000000;

  // Bus access drops in the same edge the fatal flag rises, so no new
  // access can slip out after the error.
  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      RDATA <= nsis_pkg::RDATA_RST;
      BUS_ACCESS_EN <= 1'b1;
      IRQ <= 1'b0;
    end
    else
    begin
      RDATA <= rdata_d;
      BUS_ACCESS_EN <= ~fatal_next;
      IRQ <= normal_q | abnormal_q;
    end
  end

  assign NORMAL_SUMMARY = normal_q;
  assign ABNORMAL_SUMMARY = abnormal_q;

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RESETN);

  sequence s_tx_done_only;
    set_v[0] && !set_v[10];
  endsequence

  a_etx_autoclr: assert property (
    s_tx_done_only |=> !flag_q[10])
    else $error("early transmit flag not cleared by transmit done");
  a_erx_autoclr: assert property (
    set_v[6] && !set_v[14] |=> !flag_q[14])
    else $error("early receive flag not cleared by receive done");
  a_erx_set: assert property (
    set_v[14] |=> flag_q[14])
    else $error("early receive event lost");
  a_fatal_record: assert property (
    set_v[13] |=> flag_q[13] && err_type_q == $past(BUS_ERR_TYPE))
    else $error("fatal flag or error type not recorded");
  a_bus_stopped: assert property (
    flag_q[13] |-> !BUS_ACCESS_EN)
    else $error("bus access enabled during fatal error");
  a_w1c_clear: assert property (
    wr_status && WDATA[11] && !set_v[11] |=> !flag_q[11])
    else $error("write one did not clear the flag");
  a_w0_keep: assert property (
    flag_q[11] && !(wr_status && WDATA[11]) |=> flag_q[11])
    else $error("flag lost without a write one");
  a_read_stable: assert property (
    RD && !WR && set_v == 28'h0000000 |=> $stable(flag_q))
    else $error("read changed the flags");
  a_state_mirror: assert property (
    1'b1 |=> tx_state_q == $past(TX_STATE))
    else $error("transmit state field not mirrored");

  // ----------------------------------------------------------------------
  // Register bus and flag checks.
  // ----------------------------------------------------------------------
  // Read data must be zero outside the cycle after a read strobe.
  a_rdata_idle: assert property (
    !RD |=> RDATA == 32'h00000000)
    else $error("read data not zero outside a read");
  // A status read shows the summaries as they stood at the strobe.
  a_status_read: assert property (
    RD && sel_status |=> RDATA[31:28] == 4'h0
      && RDATA[16] == $past(normal_q) && RDATA[15] == $past(abnormal_q))
    else $error("status read shows wrong summary bits");
  // Mask positions with no flag behind them always read zero.
  a_mask_read: assert property (
    RD && sel_mask |=> RDATA[31:28] == 4'h0 && RDATA[25:15] == 11'h000)
    else $error("mask read shows unimplemented bits");
  // The field positions of the status word never hold a flag.
  a_flag_gap: assert property (
    flag_q[25:15] == 11'h000)
    else $error("flag set in a field position");
  // Every event lands, even against a clear in the same cycle.
  a_set_wins: assert property (
    1'b1 |=> (flag_q & $past(set_v)) == $past(set_v))
    else $error("event lost against a clear");
  // Clearing the fatal flag gives the bus back at once.
  a_fatal_w1c: assert property (
    wr_status && WDATA[13] && !set_v[13] |=> !flag_q[13] && BUS_ACCESS_EN)
    else $error("fatal flag clear did not restore bus access");
  // A fresh early transmit event beats the completion sweep.
  a_etx_set_wins: assert property (
    set_v[0] && set_v[10] |=> flag_q[10])
    else $error("early transmit event lost to auto clear");
  // Early transmit leaves only by completion or a write of one.
  a_etx_keep: assert property (
    flag_q[10] && !set_v[0] && !clr_v[10] |=> flag_q[10])
    else $error("early transmit flag dropped without cause");
  // Early receive leaves only by completion or a write of one.
  a_erx_keep: assert property (
    flag_q[14] && !set_v[6] && !clr_v[14] |=> flag_q[14])
    else $error("early receive flag dropped without cause");
  // A fresh early receive event beats the completion sweep.
  a_erx_set_wins: assert property (
    set_v[6] && set_v[14] |=> flag_q[14])
    else $error("early receive event lost to auto clear");
  // The error cause moves only with a fatal event.
  a_err_keep: assert property (
    !set_v[13] |=> $stable(err_type_q))
    else $error("error type changed without a fatal event");
  // The receive state field is a one-cycle mirror.
  a_rx_mirror: assert property (
    1'b1 |=> rx_state_q == $past(RX_STATE))
    else $error("receive state field not mirrored");
  // A mask bit written as one enables its flag.
  a_mask_one: assert property (
    wr_mask && WDATA[13] |=> mask_q[13])
    else $error("mask bit not set by write");
  // A mask bit written as zero masks its flag.
  a_mask_zero: assert property (
    wr_mask && !WDATA[13] |=> !mask_q[13])
    else $error("mask bit not cleared by write");
  // The mask only changes on a mask write.
  a_mask_keep: assert property (
    !wr_mask |=> $stable(mask_q))
    else $error("mask changed without a write");
  // The interrupt line trails the summaries by one register stage.
  a_irq_level: assert property (
    1'b1 |=> IRQ == ($past(normal_q) || $past(abnormal_q)))
    else $error("interrupt line does not follow summaries");

  // ----------------------------------------------------------------------
  // Early transmit hold checks.
  // ----------------------------------------------------------------------
  // The hold lives until software writes one to early transmit.
  sequence s_hold_live;
    hold_q && !etx_sw_clr;
  endsequence

  // Software release with no new auto clear in the same cycle.
  sequence s_hold_drop;
    hold_q && etx_sw_clr && !etx_auto;
  endsequence

  // A living hold keeps the abnormal summary up.
  a_hold_keep: assert property (
    s_hold_live |=> hold_q && ABNORMAL_SUMMARY)
    else $error("hold or abnormal summary lost too early");
  // A write of one to early transmit ends the hold.
  a_hold_drop: assert property (
    s_hold_drop |=> !hold_q)
    else $error("hold not released by software");
  // The held summary reaches the interrupt line two cycles on.
  a_hold_irq: assert property (
    hold_q |-> ##2 IRQ)
    else $error("interrupt line low during hold");

endmodule : nsis_top

/* tb/nsis_top_tb.sv */
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Self-checking bench for the status and interrupt summary block.
// ----------------------------------------------------------------------
module nsis_top_tb;
  logic clk = 1'h0;
  logic resetn = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic wstb = 1'h0;
  logic rstb = 1'h0;
  logic [31:0] rdata;
  logic [27:0] ev_set = 28'h0000000;
  logic [2:0] err_ty = 3'h0;
  logic [2:0] tx_s = 3'h0;
  logic [2:0] rx_s = 3'h0;
  logic bus_en, irq, nrm, abn, rd_d;
  logic [27:0] flags_e = 28'h0000000;
  logic [27:0] mask_e = 28'h0000000;
  logic [2:0] err_e = 3'h0;
  logic hold_e = 1'h0;
  logic [31:0] exp_q[$];
  int mismatches = 0;
  int n_compared = 0;
  int cyc = 0;

  nsis_top i_dut (.CLK(clk), .RESETN(resetn), .ADDR(addr), .WDATA(wdata),
    .WR(wstb), .RD(rstb), .RDATA(rdata), .EVENT_SET(ev_set),
    .BUS_ERR_TYPE(err_ty), .TX_STATE(tx_s), .RX_STATE(rx_s),
    .BUS_ACCESS_EN(bus_en), .IRQ(irq), .NORMAL_SUMMARY(nrm),
    .ABNORMAL_SUMMARY(abn));

  // Free-running clock at 100 MHz.
  always #5 clk = ~clk;

  // ----------------------------------------------------------------------
  // Comparison and closing tasks
  // ----------------------------------------------------------------------
  task automatic end_sim();
    if (mismatches == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : end_sim

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t read got %h exp %h", $time, got, exp);
    end
  endtask : cmp32

  task automatic cmp1(input logic got, input logic exp, input string what);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("MISMATCH %0t %s got %b exp %b", $time, what, got, exp);
    end
  endtask : cmp1

  // Expected status word; summaries are not sticky except for the hold.
  function automatic logic [31:0] exp_status();
    logic [27:0] m;
    m = flags_e & mask_e;
    return {4'h0, flags_e[27:26], err_e, tx_s, rx_s,
      |(m & nsis_pkg::NORMAL_SRC),
      (|(m & nsis_pkg::ABNORMAL_SRC)) | hold_e, flags_e[14:0]};
  endfunction : exp_status

  // ----------------------------------------------------------------------
  // Bus and event drivers, each updating the expected state
  // ----------------------------------------------------------------------
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : settle

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wstb <= 1'h1;
    @(posedge clk);
    wstb <= 1'h0;
    if (a == nsis_pkg::STATUS_OFF)
    begin
      flags_e &= ~(d[27:0] & nsis_pkg::FLAG_IMPL);
      if (d[10])
        hold_e = 1'h0;
    end
    else if (a == nsis_pkg::MASK_OFF)
      mask_e = d[27:0] & nsis_pkg::FLAG_IMPL;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rstb <= 1'h1;
    exp_q.push_back(e);
    @(posedge clk);
    rstb <= 1'h0;
  endtask : bus_rd

  // The hold arms only when early transmit is enabled and tx done masked.
  task automatic pulse(input logic [27:0] b, input logic [2:0] t);
    @(posedge clk);
    ev_set <= b;
    err_ty <= t;
    @(posedge clk);
    ev_set <= 28'h0000000;
    if (b[0])
    begin
      if (flags_e[10] && mask_e[10] && !mask_e[0])
        hold_e = 1'h1;
      flags_e[10] = 1'h0;
    end
    if (b[6])
      flags_e[14] = 1'h0;
    flags_e |= b & nsis_pkg::FLAG_IMPL;
    if (b[13])
      err_e = t;
  endtask : pulse

  task automatic chk_lvl();
    logic n, a;
    n = |(flags_e & mask_e & nsis_pkg::NORMAL_SRC);
    a = (|(flags_e & mask_e & nsis_pkg::ABNORMAL_SRC)) | hold_e;
    cmp1(nrm, n, "normal");
    cmp1(abn, a, "abnormal");
    cmp1(irq, n | a, "irq");
    cmp1(bus_en, ~flags_e[13], "bus access");
    bus_rd(nsis_pkg::STATUS_OFF, exp_status());
  endtask : chk_lvl

  // ----------------------------------------------------------------------
  // Read monitor: takes the oldest note whenever read data stand
  // ----------------------------------------------------------------------
  always @(posedge clk)
    rd_d <= rstb;

  always @(negedge clk)
  begin
    if (rd_d === 1'h1)
      cmp32(rdata, exp_q.pop_front());
  end

  // Hang guard, far above the roughly 480 cycles the run needs.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      mismatches++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    void'($urandom(32'h03A4));
    repeat (2) @(posedge clk);
    resetn <= 1'h1;
    settle(1);
    chk_lvl();
    bus_rd(nsis_pkg::MASK_OFF, 32'h00000000);
    bus_wr(8'h30, 32'hFFFFFFFF);
    bus_rd(8'h30, 32'h00000000);
    bus_wr(nsis_pkg::MASK_OFF, 32'hFFFFFFFF);
    bus_rd(nsis_pkg::MASK_OFF, {4'h0, nsis_pkg::FLAG_IMPL});
    // Every flag alone: set, survive a zero write and a reread, clear.
    for (int i = 0; i < 28; i++)
    begin
      if (nsis_pkg::FLAG_IMPL[i])
      begin
        tx_s <= 3'($urandom);
        rx_s <= 3'($urandom);
        pulse(28'h1 << i, 3'($urandom));
        settle(4);
        chk_lvl();
        bus_wr(nsis_pkg::STATUS_OFF, 32'h00000000);
        bus_rd(nsis_pkg::STATUS_OFF, exp_status());
        bus_wr(nsis_pkg::STATUS_OFF, 32'h1 << i);
        settle(4);
        chk_lvl();
      end
    end
    // One random burst with all masked, then six random masks.
    bus_wr(nsis_pkg::MASK_OFF, 32'h00000000);
    pulse(28'($urandom), 3'($urandom));
    settle(4);
    chk_lvl();
    for (int k = 0; k < 6; k++)
    begin
      bus_wr(nsis_pkg::MASK_OFF, $urandom);
      settle(4);
      chk_lvl();
    end
    bus_wr(nsis_pkg::STATUS_OFF, 32'hFFFFFFFF);
    // Early transmit hold, with tx done masked and then unmasked.
    for (int m = 0; m < 2; m++)
    begin
      bus_wr(nsis_pkg::MASK_OFF, m ? 32'h00000401 : 32'h00000400);
      pulse(28'h0000400, 3'h0);
      pulse(28'h0000001, 3'h0);
      settle(4);
      chk_lvl();
      bus_wr(nsis_pkg::STATUS_OFF, 32'h00000400);
      settle(4);
      chk_lvl();
      bus_wr(nsis_pkg::STATUS_OFF, 32'h00000001);
    end
    // Receive done clears early receive.
    bus_wr(nsis_pkg::MASK_OFF, 32'h00004000);
    pulse(28'h0004000, 3'h0);
    pulse(28'h0000040, 3'h0);
    settle(4);
    chk_lvl();
    settle(4);
    end_sim();
  end
endmodule : nsis_top_tb
